//--- inc/adcres_pkg.sv
// Package: offsets, widths and reset values of the result bank
package adcres_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets (MSB at offset, LSB at offset + 1)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADCRES_OFS_IBUS = 8'h31;
  localparam logic [7:0] ADCRES_OFS_IBAT = 8'h33;
  localparam logic [7:0] ADCRES_OFS_VBUS = 8'h35;
  localparam logic [7:0] ADCRES_OFS_VAC1 = 8'h37;
  localparam logic [7:0] ADCRES_OFS_VAC2 = 8'h39;
  localparam logic [7:0] ADCRES_OFS_VBAT = 8'h3B;
  localparam logic [7:0] ADCRES_OFS_VSYS = 8'h3D;

  // ---------------------------------------------------------------
  // Channels, widths and reset values
  // ---------------------------------------------------------------
  localparam int          ADCRES_NCH      = 7;
  localparam int          ADCRES_CHW      = 3;
  localparam int          ADCRES_DW       = 16;
  localparam logic [15:0] ADCRES_RST_VAL  = 16'h0000;
  localparam logic [7:0]  ADCRES_RD_NONE  = 8'h00;
  localparam logic [1:0]  ADCRES_SPD_RST  = 2'h3;
  localparam logic [2:0]  ADCRES_CH_LAST  = 3'h6;

  // Channel order: ibus, ibat, vbus, vac1, vac2, vbat, vsys
  localparam logic [7:0] ADCRES_OFS_TAB [ADCRES_NCH] = '{
    ADCRES_OFS_IBUS, ADCRES_OFS_IBAT, ADCRES_OFS_VBUS, ADCRES_OFS_VAC1,
    ADCRES_OFS_VAC2, ADCRES_OFS_VBAT, ADCRES_OFS_VSYS};

  // Converter sequencing
  typedef enum logic [1:0] {
    ADCRES_IDLE = 2'b00,
    ADCRES_RUN  = 2'b01,
    ADCRES_DONE = 2'b10
  } adcres_state_e;

endpackage : adcres_pkg

//--- logic/adcres_bank.sv
// Result register bank of the monitoring converter
`timescale 1ns/1ns

module adcres_bank
  import adcres_pkg::*;
#(
  parameter int NCH = ADCRES_NCH
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // Converter control (from the control register)
  input  wire logic                conv_enable,
  input  wire logic                conv_one_shot,
  input  wire logic [1:0]          sample_speed,
  input  wire logic                average_enable,
  input  wire logic                average_start_select,
  input  wire logic [NCH-1:0]      channel_disable,
  // Raw conversion result, same clock domain
  input  wire logic                conv_done,
  input  wire logic [2:0]          conv_channel,
  input  wire logic [15:0]         conv_data,
  // Converter sequencing
  output logic                     conv_start,
  output logic [2:0]               conv_select,
  output logic [1:0]               conv_speed,
  output logic                     conv_busy,
  // Serial register port, read side
  input  wire logic [7:0]          rd_addr,
  output logic [7:0]               rd_data
);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  adcres_state_e    state_r;
  adcres_state_e    state_nxt;
  logic [2:0]       chan_r;
  logic             start_r;
  logic [1:0]       speed_r;
  logic             busy_r;
  logic [NCH-1:0]   avg_primed_r;

  wire logic        last_chan  = (chan_r == ADCRES_CH_LAST);
  wire logic        this_done  = conv_done && (conv_channel == chan_r);
  wire logic        chan_skip  = channel_disable[chan_r];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCRES_IDLE: begin
        if (conv_enable)
          state_nxt = ADCRES_RUN;
      end
      ADCRES_RUN: begin
        if (!conv_enable)
          state_nxt = ADCRES_IDLE;
        else if ((this_done || chan_skip) && last_chan)
          state_nxt = ADCRES_DONE;
      end
      ADCRES_DONE: begin
        // Continuous restarts; one shot parks until enable drops
        if (!conv_enable)
          state_nxt = ADCRES_IDLE;
        else if (!conv_one_shot)
          state_nxt = ADCRES_RUN;
      end
      default: state_nxt = ADCRES_IDLE;
    endcase
  end

  wire logic advance  = (state_r == ADCRES_RUN) && (this_done || chan_skip);
  wire logic kick     = (state_nxt == ADCRES_RUN) &&
                        ((state_r != ADCRES_RUN) || advance);
  wire logic [2:0] kick_chan = (state_r == ADCRES_RUN && !last_chan) ?
                               chan_r + 3'h1 : 3'h0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ADCRES_IDLE;
      chan_r  <= '0;
      start_r <= 1'b0;
      speed_r <= ADCRES_SPD_RST;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != ADCRES_RUN)
        chan_r <= '0;
      else if (advance)
        chan_r <= last_chan ? 3'h0 : chan_r + 3'h1;
      // Speed latched per pass so a pass uses one resolution
      if (state_r != ADCRES_RUN)
        speed_r <= sample_speed;
      start_r <= kick && !channel_disable[kick_chan];
      busy_r  <= (state_nxt == ADCRES_RUN);
    end
  end

  logic [2:0] sel_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      sel_r <= '0;
    else if (kick)
      sel_r <= kick_chan;
  end

  assign conv_start  = start_r;
  assign conv_select = sel_r;
  assign conv_speed  = speed_r;
  assign conv_busy   = busy_r;

  // ---------------------------------------------------------------
  // Result registers, one per channel
  // ---------------------------------------------------------------
  logic [15:0] result_r [NCH];
  logic [7:0]  rd_data_r;
  logic [NCH-1:0] hit_msb;
  logic [NCH-1:0] hit_lsb;

  // Signed sum halves; arithmetic shift keeps the sign
  function automatic logic [15:0] avg2(input logic [15:0] a,
                                       input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    return s[16:1];
  endfunction : avg2

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic upd = conv_done && (conv_channel == 3'(g)) &&
                       (state_r == ADCRES_RUN);
      wire logic first = !avg_primed_r[g] && average_start_select;
      wire logic [15:0] nxt = (average_enable && !first) ?
                              avg2(result_r[g], conv_data) : conv_data;
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          result_r[g]     <= ADCRES_RST_VAL;
          avg_primed_r[g] <= 1'b0;
        end else begin
          // Whole word written once, on completion only
          if (upd)
            result_r[g] <= nxt;
          if (!average_enable)
            avg_primed_r[g] <= 1'b0;
          else if (upd)
            avg_primed_r[g] <= 1'b1;
        end
      end
      // Two's complement data passes through unscaled, no offset
      assign hit_msb[g] = (rd_addr == ADCRES_OFS_TAB[g]);
      assign hit_lsb[g] = (rd_addr == ADCRES_OFS_TAB[g] + 8'h01);
    end
  endgenerate
  // Channel 0..6: map by index

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_sel;
  always_comb begin
    rd_sel = ADCRES_RD_NONE;
    for (int i = 0; i < NCH; i++) begin
      if (hit_msb[i])
        rd_sel = result_r[i][15:8];
      if (hit_lsb[i])
        rd_sel = result_r[i][7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      rd_data_r <= ADCRES_RD_NONE;
    else
      rd_data_r <= rd_sel;
  end

  assign rd_data = rd_data_r;

endmodule : adcres_bank

//--- tb/adcres_bank_sva.sv
// Checker for the result register bank
`timescale 1ns/1ns
module adcres_bank_sva
  import adcres_pkg::*;
#(parameter int NCH = ADCRES_NCH) (
  // Clock, reset and converter side
  input wire logic           sys_clk,
  input wire logic           sys_rst,
  input wire logic           conv_enable,
  input wire logic [NCH-1:0] channel_disable,
  input wire logic           conv_done,
  input wire logic           conv_start,
  input wire logic [2:0]     conv_select,
  input wire logic [1:0]     conv_speed,
  input wire logic           conv_busy,
  // Read side
  input wire logic [7:0]     rd_addr,
  input wire logic [7:0]     rd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rst; disable iff (1'b0)
    sys_rst |=> rd_data == 8'h00 && !conv_busy && conv_speed == 2'h3;
  endproperty
  property p_unmap; (rd_addr < 8'h31 || rd_addr > 8'h3E) |=> !rd_data;
  endproperty
  // Results move only on a completed conversion
  property p_hold; !conv_done ##1 $stable(rd_addr) |=> $stable(rd_data);
  endproperty
  property p_busy; conv_start |-> conv_busy; endproperty
  property p_pulse; conv_start |=> !conv_start; endproperty
  property p_sel;
    conv_start |-> conv_select <= ADCRES_CH_LAST
      && !channel_disable[conv_select];
  endproperty
  property p_go;
    $rose(conv_enable) && !conv_busy && channel_disable != '1
      |-> ##[1:8] conv_start;
  endproperty
  property p_idle; !conv_busy && !conv_enable |=> !conv_start; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_unmap: assert property (p_unmap) else $error("unmapped byte");
  a_hold: assert property (p_hold) else $error("result moved");
  a_busy: assert property (p_busy) else $error("start idle");
  a_pulse: assert property (p_pulse) else $error("start width");
  a_sel: assert property (p_sel) else $error("bad channel");
  a_go: assert property (p_go) else $error("no start");
  a_idle: assert property (p_idle) else $error("stray start");
  c_start: cover property (conv_start);
  c_end: cover property ($fell(conv_busy));
  c_done: cover property (conv_done && conv_busy);
endmodule : adcres_bank_sva
bind adcres_bank adcres_bank_sva #(.NCH(NCH)) u_sva (.*);

//--- tb/adcres_bank_tb.sv
// Self-checking bench for the result register bank
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module adcres_bank_tb;
  import adcres_pkg::*;
  logic sys_clk = 0, sys_rst = 1, conv_enable = 0, conv_one_shot = 1;
  logic average_enable = 0, average_start_select = 0, conv_done = 0;
  logic [1:0]  sample_speed = 0;
  logic [6:0]  channel_disable = 0;
  logic [2:0]  conv_channel = 0;
  logic [15:0] conv_data = 0;
  logic [7:0]  rd_addr = 0, exp8;
  logic        rd_req = 0, pend = 0, conv_start, conv_busy;
  logic [2:0]  conv_select;
  logic [1:0]  conv_speed;
  logic [7:0]  rd_data;
  logic [15:0] val [7], res [7] = '{default: 16'h0000};
  logic [7:0]  q [$];
  int          failures = 0, total_checks = 0, nst = 0;
  adcres_bank dut (.*);
  always #20 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // Converter responder and read monitor
  // ---------------------------------------------------------------
  function automatic logic [15:0] avg(logic [15:0] a, logic [15:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    return s[16:1];
  endfunction : avg
  initial forever begin
    @(negedge sys_clk);
    if (conv_start === 1'b1) begin
      automatic logic [2:0] c = conv_select;
      `CHK(conv_speed, sample_speed)
      nst++;
      repeat ($urandom % 3 + 1) @(posedge sys_clk);
      conv_done <= 1'b1;
      conv_channel <= c;
      conv_data <= val[c];
      // A result landing after enable dropped is ignored by the bank
      if (conv_enable)
        res[c] <= average_enable ? avg(res[c], val[c]) : val[c];
      @(posedge sys_clk) conv_done <= 1'b0;
    end
  end
  always @(posedge sys_clk) pend <= rd_req;
  always @(negedge sys_clk) if (pend) begin
    exp8 = q.pop_front();
    `CHK(rd_data, exp8)
  end
  // 0x30 and 0x3F are the unmapped neighbours of the bank
  task automatic rd_all();
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      rd_addr <= 8'h30 + 8'(i);
      rd_req <= 1'b1;
      q.push_back(i == 0 || i == 15 ? 8'h00 :
                  (i % 2 ? res[i/2][15:8] : res[i/2 - 1][7:0]));
    end
    @(posedge sys_clk) rd_req <= 1'b0;
  endtask : rd_all
  task automatic pass(logic [6:0] dis, logic cont);
    int n;
    n = nst;
    @(posedge sys_clk);
    channel_disable <= dis;
    conv_one_shot <= !cont;
    sample_speed <= 2'($urandom);
    @(posedge sys_clk) conv_enable <= 1'b1;
    repeat (cont ? 400 : 10) @(posedge sys_clk);
    if (cont) `CHK(nst > n + 7, 1'b1)
    conv_enable <= !cont;
    for (int t = 0; t < 300 && conv_busy !== 1'b0; t++) @(posedge sys_clk);
    @(posedge sys_clk) conv_enable <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CHK(conv_busy, 1'b0)
  endtask : pass
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  // Range limits first, then random even readings so averages stay exact
  initial begin
    void'($urandom(32'h115F));
    val = '{16'h1388, 16'hE0C0, 16'h7530, 16'h7530, 16'h8AD0, 16'h4E20,
            16'h5DC0};
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_all();
    for (int p = 0; p < 6; p++) begin
      average_enable <= p == 3 || p == 4;
      pass(p > 0 && p < 5 ? 7'($urandom) : 7'h00, p == 5);
      rd_all();
      for (int c = 0; c < 7; c++) val[c] = 16'($urandom) & 16'hFFFE;
    end
    end_of_test();
  end
endmodule : adcres_bank_tb
